// ### primitive_request_decoder.sv
`timescale 1ns/1ps
`default_nettype none

// Small flop FIFO; outReady low lets it fill and drop inReady
module octet_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr, rdPtr;
	logic [AW:0] count;
	wire push = ce && inValid && inReady;
	wire pop = ce && outValid && outReady;

	assign inReady = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];

	// Pointers wrap at DEPTH, not at a power of two
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push)
				wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			if (pop)
				rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage has no reset; only written slots are ever read
	always_ff @(posedge clk) begin
		if (push)
			mem[wrPtr] <= inData;
	end
endmodule : octet_fifo

module primitive_request_decoder #(
	parameter logic [7:0] MAX_TYPE = 8'h1f,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic x25Mode,
	input wire logic reqValid,
	output logic reqReady,
	input wire prd_pkg::octet_t reqOctet,
	output logic respValid,
	input wire logic respReady,
	output prd_pkg::octet_t respOctet,
	output logic carrierX25,
	output logic execStart,
	output logic [7:0] cmdCode,
	output logic cmdExtended,
	input wire logic execDone,
	input wire logic execFault,
	input wire logic [7:0] deviceStatus
);
	prd_pkg::state_t st;
	logic [15:0] length;
	logic [15:0] count;
	logic [7:0] lenHigh;
	logic [7:0] reason;
	logic [7:0] status;
	logic faulted;
	logic [2:0] respIdx;
	logic fifoInReady;
	prd_pkg::octet_t pushOctet;

	// Request side decode
	wire acc = ce && reqValid && reqReady;
	wire isLast = reqOctet.last;
	wire [7:0] inByte = reqOctet.data;
	wire [15:0] lenNow = {lenHigh, inByte};
	wire [15:0] cntNext = count + prd_pkg::LEN_ONE;
	wire prd_pkg::group_t grp = prd_pkg::codeGroup(cmdCode);
	wire needsType = (grp == prd_pkg::GRP_READ) || (grp == prd_pkg::GRP_WRITE);
	wire typeOk = (inByte != prd_pkg::TYPE_NONE) && (inByte <= MAX_TYPE);
	wire prd_pkg::group_t inGrp = prd_pkg::codeGroup(inByte);
	wire codeBad = (inGrp == prd_pkg::GRP_UNDEF) ||
		(inGrp == prd_pkg::GRP_EXPAND) || !prd_pkg::codeSupported(inByte);
	wire lenBad = (lenNow == prd_pkg::LEN_NONE) || (lenNow > prd_pkg::MAX_LEN);
	wire overRun = cntNext > length;
	wire shortLast = isLast && (cntNext < length);
	wire typeByte = needsType && (cntNext == prd_pkg::LEN_TYPED);

	assign reqReady = ce && (st == prd_pkg::ST_LENHI ||
		st == prd_pkg::ST_LENLO || st == prd_pkg::ST_CODE ||
		st == prd_pkg::ST_DRAIN ||
		(st == prd_pkg::ST_BODY && count != prd_pkg::LEN_NONE));

	// Response octet selection, length field first, high octet first
	wire [15:0] respLen = faulted ? prd_pkg::EXC_RESP_LEN : prd_pkg::OK_RESP_LEN;
	wire [2:0] respBytes = faulted ? prd_pkg::EXC_BYTES : prd_pkg::OK_BYTES;
	wire respLastIdx = (respIdx == respBytes - 3'h1);
	wire [7:0] respByte2 = faulted ? prd_pkg::CODE_EXCEPTION : cmdCode;
	wire [7:0] respByte3 = faulted ? reason : status;
	wire [7:0] respSel = (respIdx == 3'h0) ? respLen[15:8] :
		(respIdx == 3'h1) ? respLen[7:0] :
		(respIdx == 3'h2) ? respByte2 :
		(respIdx == 3'h3) ? respByte3 : cmdCode;
	wire pushValid = (st == prd_pkg::ST_RESP);
	wire push = ce && pushValid && fifoInReady;
	assign pushOctet = '{data: respSel, last: respLastIdx};

	// Main sequencer; a decode fault drains the rest of the frame, no execution
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= prd_pkg::ST_LENHI;
			length <= '0;
			count <= '0;
			lenHigh <= '0;
			reason <= '0;
			status <= '0;
			faulted <= 1'b0;
			respIdx <= '0;
			cmdCode <= '0;
			cmdExtended <= 1'b0;
			carrierX25 <= 1'b0;
			execStart <= 1'b0;
		end else if (ce) begin
			execStart <= 1'b0;
			case (st)
				prd_pkg::ST_LENHI: begin
					if (acc) begin
						carrierX25 <= x25Mode;
						lenHigh <= inByte;
						count <= '0;
						faulted <= isLast;
						reason <= prd_pkg::REASON_LENGTH;
						st <= isLast ? prd_pkg::ST_RESP : prd_pkg::ST_LENLO;
					end
				end
				prd_pkg::ST_LENLO: begin
					if (acc) begin
						length <= lenNow;
						faulted <= lenBad || isLast;
						st <= isLast ? prd_pkg::ST_RESP :
							lenBad ? prd_pkg::ST_DRAIN : prd_pkg::ST_CODE;
					end
				end
				prd_pkg::ST_CODE: begin
					if (acc) begin
						cmdCode <= inByte;
						cmdExtended <= inByte[prd_pkg::EXT_BIT];
						count <= isLast ? prd_pkg::LEN_NONE : cntNext;
						if (codeBad || shortLast) begin
							faulted <= 1'b1;
							reason <= codeBad ? prd_pkg::REASON_FORMAT :
								prd_pkg::REASON_LENGTH;
							st <= isLast ? prd_pkg::ST_RESP : prd_pkg::ST_DRAIN;
						end else
							st <= prd_pkg::ST_BODY;
					end
				end
				prd_pkg::ST_BODY: begin
					// Zero count here marks a code-only request already ended
					if (count == prd_pkg::LEN_NONE) begin
						if (needsType) begin
							faulted <= 1'b1;
							reason <= prd_pkg::REASON_FORMAT;
							st <= prd_pkg::ST_RESP;
						end else begin
							execStart <= 1'b1;
							st <= prd_pkg::ST_EXEC;
						end
					end else if (acc) begin
						count <= cntNext;
						if (overRun || shortLast) begin
							faulted <= 1'b1;
							reason <= prd_pkg::REASON_LENGTH;
							st <= isLast ? prd_pkg::ST_RESP : prd_pkg::ST_DRAIN;
						end else if (typeByte && !typeOk) begin
							faulted <= 1'b1;
							reason <= prd_pkg::REASON_TYPE;
							st <= isLast ? prd_pkg::ST_RESP : prd_pkg::ST_DRAIN;
						end else if (isLast) begin
							execStart <= 1'b1;
							st <= prd_pkg::ST_EXEC;
						end
					end
				end
				prd_pkg::ST_DRAIN: begin
					if (acc && isLast)
						st <= prd_pkg::ST_RESP;
				end
				prd_pkg::ST_EXEC: begin
					// A failed write may be partly done; host must confirm
					if (execDone) begin
						status <= deviceStatus;
						faulted <= execFault;
						reason <= execFault ? prd_pkg::REASON_EXEC : reason;
						st <= prd_pkg::ST_RESP;
					end
				end
				prd_pkg::ST_RESP: begin
					if (push) begin
						respIdx <= respIdx + 3'h1;
						if (respLastIdx) begin
							respIdx <= '0;
							st <= prd_pkg::ST_LENHI;
						end
					end
				end
				default: st <= prd_pkg::ST_LENHI;
			endcase
		end
	end

	// Response buffer; its full flag stalls the emitter above
	octet_fifo #(.WIDTH($bits(prd_pkg::octet_t)), .DEPTH(FIFO_DEPTH)) respFifo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.inValid(pushValid),
		.inReady(fifoInReady),
		.inData(pushOctet),
		.outValid(respValid),
		.outReady(respReady),
		.outData(respOctet)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence lenOctetTooBig;
		st == prd_pkg::ST_LENLO && acc && lenNow > prd_pkg::MAX_LEN;
	endsequence
	sequence faultMidFrame;
		st == prd_pkg::ST_CODE && acc && codeBad && !isLast;
	endsequence

	len_limit_a: assert property (lenOctetTooBig |=> faulted &&
		reason == prd_pkg::REASON_LENGTH)
		else $error("oversize length not faulted");
	abort_drain_a: assert property (faultMidFrame |=> st == prd_pkg::ST_DRAIN
		&& !execStart) else $error("fault did not abort");
	bad_code_a: assert property (st == prd_pkg::ST_EXEC |->
		grp != prd_pkg::GRP_UNDEF && grp != prd_pkg::GRP_EXPAND &&
		prd_pkg::codeSupported(cmdCode)) else $error("bad code executed");
	exc_code_a: assert property (push && faulted && respIdx == 3'h2 |->
		pushOctet.data == prd_pkg::CODE_EXCEPTION)
		else $error("exception code wrong");
	ok_resp_a: assert property (st == prd_pkg::ST_EXEC && ce && execDone &&
		!execFault |=> st == prd_pkg::ST_RESP && !faulted)
		else $error("good request not answered");
	ext_addr_a: assert property (st == prd_pkg::ST_EXEC |->
		cmdExtended == cmdCode[prd_pkg::EXT_BIT])
		else $error("extended flag mismatch");
	resp_len_a: assert property (push && respIdx == 3'h1 |->
		pushOctet.data == respLen[7:0] && !pushOctet.last)
		else $error("length octet wrong");
	resp_size_a: assert property (push && pushOctet.last |->
		respIdx == respBytes - 3'h1 ##1 st == prd_pkg::ST_LENHI)
		else $error("response size wrong");
	carrier_a: assert property (st == prd_pkg::ST_LENHI && acc |=>
		carrierX25 == $past(x25Mode)) else $error("carrier not latched");
	no_take_a: assert property (st == prd_pkg::ST_EXEC ||
		st == prd_pkg::ST_RESP || (st == prd_pkg::ST_BODY &&
		count == prd_pkg::LEN_NONE) |-> !reqReady)
		else $error("request taken while busy");
endmodule : primitive_request_decoder
`default_nettype wire

// ### prd_pkg.sv
`default_nettype none
package prd_pkg;
	// Size limits of the information field, in octets
	localparam int MAX_INFO = 273;
	localparam int LEN_FIELD_BYTES = 2;
	localparam logic [15:0] MAX_LEN = 16'(MAX_INFO - LEN_FIELD_BYTES);
	localparam logic [15:0] LEN_NONE = 16'h0000;
	localparam logic [15:0] LEN_ONE = 16'h0001;
	localparam logic [15:0] LEN_TYPED = 16'h0002;
	// Code byte layout
	localparam int EXT_BIT = 7;
	localparam logic [7:0] CODE_EXCEPTION = 8'h00;
	localparam logic [7:0] TYPE_NONE = 8'h00;
	// Response lengths: value of length field and total octets sent
	localparam logic [15:0] OK_RESP_LEN = 16'h0002;
	localparam logic [15:0] EXC_RESP_LEN = 16'h0003;
	localparam logic [2:0] OK_BYTES = 3'h4;
	localparam logic [2:0] EXC_BYTES = 3'h5;
	// Exception reasons
	localparam logic [7:0] REASON_LENGTH = 8'h01;
	localparam logic [7:0] REASON_FORMAT = 8'h02;
	localparam logic [7:0] REASON_TYPE = 8'h03;
	localparam logic [7:0] REASON_EXEC = 8'h04;

	typedef enum logic [2:0] {
		GRP_STATUS = 3'h0,
		GRP_CONTROL = 3'h1,
		GRP_READ = 3'h2,
		GRP_WRITE = 3'h3,
		GRP_AIDS = 3'h4,
		GRP_ACQ = 3'h5,
		GRP_UNDEF = 3'h6,
		GRP_EXPAND = 3'h7
	} group_t;

	typedef enum logic [2:0] {
		ST_LENHI = 3'h0,
		ST_LENLO = 3'h1,
		ST_CODE = 3'h2,
		ST_BODY = 3'h3,
		ST_DRAIN = 3'h4,
		ST_EXEC = 3'h5,
		ST_RESP = 3'h6
	} state_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} octet_t;

	// Extended codes fall in the same group as their low seven bits
	function automatic group_t codeGroup(input logic [7:0] code);
		logic [6:0] low;
		low = code[6:0];
		if (low <= 7'h0f) return GRP_STATUS;
		else if (low <= 7'h1f) return GRP_CONTROL;
		else if (low <= 7'h2f) return GRP_READ;
		else if (low <= 7'h3f) return GRP_WRITE;
		else if (low <= 7'h4f) return GRP_AIDS;
		else if (low <= 7'h6f) return GRP_ACQ;
		else if (low <= 7'h7e) return GRP_UNDEF;
		else return GRP_EXPAND;
	endfunction : codeGroup

	// Supported subset, both addressing forms
	function automatic logic codeSupported(input logic [7:0] code);
		case (code[6:0])
			7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h10, 7'h20, 7'h21,
			7'h30, 7'h31, 7'h50, 7'h51, 7'h52, 7'h55, 7'h56, 7'h57: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : codeSupported
endpackage : prd_pkg
`default_nettype wire

// ### exec_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Attached side: answers each start after a delay the bench picks
module exec_partner #(
	parameter logic [7:0] STATUS = 8'h5a
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic execStart,
	input wire logic faultReq,
	input wire logic [3:0] delay,
	output logic execDone,
	output logic execFault,
	output logic [7:0] deviceStatus
);
	logic [4:0] waitCount;
	logic busy;

	// Count down, then one done cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			waitCount <= 5'h00;
			execDone <= 1'b0;
		end else begin
			execDone <= busy && waitCount == 5'h00;
			if (execStart) begin
				busy <= 1'b1;
				waitCount <= {1'b0, delay};
			end else if (busy && waitCount != 5'h00) begin
				waitCount <= waitCount - 5'h01;
			end else begin
				busy <= 1'b0;
			end
		end
	end

	// Junk outside the done cycle, so a stale sample shows up
	assign execFault = execDone ? faultReq : ~faultReq;
	assign deviceStatus = execDone ? STATUS : ~STATUS;
endmodule : exec_partner
`default_nettype wire

// ### tb_primitive_request_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_primitive_request_decoder;
	localparam logic [7:0] STATUS = 8'h5a;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic x25Mode = 1'b0;
	logic reqValid = 1'b0;
	logic reqReady, respValid, carrierX25, execStart, cmdExtended;
	logic respReady = 1'b0;
	logic execDone, execFault, faultReq = 1'b0;
	prd_pkg::octet_t reqOctet = '0;
	prd_pkg::octet_t respOctet;
	logic [7:0] cmdCode, deviceStatus;
	logic [3:0] delay = 4'h0;
	logic [31:0] seed = 32'hacc85e60;
	logic [8:0] expQ[$];
	logic [7:0] big[$];
	int failures = 0;
	int tests_run = 0;
	int starts = 0;
	int expStarts = 0;
	int stallCycles = 0;

	primitive_request_decoder dut (.clk(clk), .rst(rst), .ce(ce),
		.x25Mode(x25Mode), .reqValid(reqValid), .reqReady(reqReady),
		.reqOctet(reqOctet), .respValid(respValid), .respReady(respReady),
		.respOctet(respOctet), .carrierX25(carrierX25),
		.execStart(execStart), .cmdCode(cmdCode), .cmdExtended(cmdExtended),
		.execDone(execDone), .execFault(execFault),
		.deviceStatus(deviceStatus));
	exec_partner #(.STATUS(STATUS)) partner (.clk(clk), .rst(rst),
		.execStart(execStart), .faultReq(faultReq), .delay(delay),
		.execDone(execDone), .execFault(execFault),
		.deviceStatus(deviceStatus));

	always #5 clk = ~clk;

	function logic [31:0] rand32();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rand32

	task automatic check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test

	// Sink stalls at random, or solidly while a fill is wanted
	always @(negedge clk) begin
		if (stallCycles > 0) stallCycles <= stallCycles - 1;
		respReady <= stallCycles == 0 && rand32() % 4 != 0;
	end

	// Each emitted octet must match the oldest noted one
	always @(posedge clk) begin
		if (!rst && ce && respValid && respReady) begin
			if (expQ.size() == 0) check("spare octet", 1, 0);
			else check("response octet", respOctet, expQ.pop_front());
		end
		if (!rst && execStart) starts++;
	end

	// Supported codes, both addressing forms alike
	function automatic logic [7:0] verdict(input logic [7:0] c);
		if (c[6:0] inside {7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h10,
			7'h20, 7'h21, 7'h30, 7'h31, 7'h50, 7'h51, 7'h52, 7'h55, 7'h56,
			7'h57}) return 8'hff;
		return 8'h02;
	endfunction : verdict

	// Offer one octet at a falling edge, hold until taken
	task automatic put(input logic [7:0] d, input logic l);
		int n;
		n = 0;
		reqValid = 1'b1;
		reqOctet = '{data: d, last: l};
		#1;
		while (!reqReady) begin
			@(negedge clk);
			#1;
			n++;
			if (n > 300) begin
				check("request taken", 0, 1);
				stop_test();
			end
		end
		@(negedge clk);
	endtask : put

	// Reason ff means a good answer; 04 asks the partner to fail
	task automatic request(input logic [15:0] len, input logic [7:0] b[$],
		input logic [7:0] reason);
		int n;
		logic mode;
		mode = 1'(rand32());
		x25Mode = mode;
		delay = 4'(rand32());
		faultReq = reason == 8'h04;
		if (reason == 8'hff || reason == 8'h04) expStarts++;
		expQ.push_back(9'h000);
		if (reason == 8'hff) begin
			expQ.push_back({8'h02, 1'b0});
			expQ.push_back({b[0], 1'b0});
			expQ.push_back({STATUS, 1'b1});
		end else begin
			expQ.push_back({8'h03, 1'b0});
			expQ.push_back(9'h000);
			expQ.push_back({reason, 1'b0});
			expQ.push_back({b[0], 1'b1});
		end
		put(len[15:8], 1'b0);
		put(len[7:0], 1'b0);
		foreach (b[i]) put(b[i], i == b.size() - 1);
		reqValid = 1'b0;
		if (stallCycles > 0) begin
			repeat (20) @(negedge clk);
			check("fifo full", {respValid, reqReady}, 2'b10);
		end
		n = 0;
		while (expQ.size() != 0 && n < 500) begin
			@(negedge clk);
			n++;
		end
		check("response drained", expQ.size(), 0);
		if (expQ.size() != 0) stop_test();
		check("carrier", carrierX25, mode);
		if (reason == 8'hff) check("extended", cmdExtended, b[0][7]);
		@(negedge clk);
	endtask : request

	initial begin
		repeat (4) @(negedge clk);
		check("reset outputs", {respValid, reqReady}, 2'b01);
		rst = 1'b0;
		@(negedge clk);
		// Every code, with a valid type octet and one spare
		for (int c = 0; c < 256; c++)
			request(16'h0003, '{8'(c), 8'h01, 8'(rand32())},
				verdict(8'(c)));
		$display("test code groups done");
		request(16'h0001, '{8'h20}, 8'h02);
		request(16'h0001, '{8'hb1}, 8'h02);
		request(16'h0002, '{8'h20, 8'h00}, 8'h03);
		request(16'h0002, '{8'h20, 8'h01}, 8'hff);
		request(16'h0002, '{8'h30, 8'h20}, 8'h03);
		request(16'h0002, '{8'ha1, 8'h1f}, 8'hff);
		$display("test data types done");
		request(16'h0003, '{8'h02}, 8'h01);
		request(16'h0001, '{8'h02, 8'h00}, 8'h01);
		request(16'h0110, '{8'h02}, 8'h01);
		request(16'h0001, '{8'h04}, 8'hff);
		big.push_back(8'h50);
		repeat (270) big.push_back(8'(rand32()));
		request(16'h010f, big, 8'hff);
		$display("test lengths done");
		request(16'h0001, '{8'h82}, 8'h04);
		stallCycles = 60;
		request(16'h0001, '{8'h70}, 8'h02);
		$display("test faults and fill done");
		ce = 1'b0;
		#1;
		check("frozen ready", reqReady, 1'b0);
		repeat (3) @(negedge clk);
		ce = 1'b1;
		request(16'h0001, '{8'h02}, 8'hff);
		check("start count", starts, expStarts);
		$display("test freeze done");
		stop_test();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		check("run time", 1, 0);
		stop_test();
	end
endmodule : tb_primitive_request_decoder
`default_nettype wire
